// ===== hdl/gate_trigger.sv
// gated sampling trigger: gate generation from ttl inputs, gate stamps,
// segment length bookkeeping, trigger output and an AHB-Lite slave.
// assumes a single whole-word AHB-Lite master and hclk as sample clock.
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - with stamping on, each gate gives a start stamp and, unless ended by a stop or start write, an end stamp
// - stamps mark gate edges; first stored sample is start stamp minus pre
// - segment length at a close is end minus start plus padding, pre and post
// - after a close, last segment sample lies at end stamp plus padding plus post
// - memsize expiry ends recording; an open gate gets one extra stamp
// - stretch 0: output high per trigger, low when segment finishes
// - stretch 1: output high on first trigger until acquisition ends
// - only inputs enabled in the source mask take part
// - rising mode: open on rising edge, close on next falling edge
// - edge modes ignore a static level present at start
// - high mode: gate open while input high, closes when low
// - level modes open at once when the level is active at start
// - rising two-edge mode: open on one rising edge, close on next
// - falling mode: open on falling edge, close on next rising edge
// - low mode: gate open while input low, closes when high
// - gate length rounds up to 4, 2 or 1 samples by channel count
module gate_trigger
  import gate_trigger_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ext_trig_in,
  input  wire logic        extra_in0,
  input  wire logic        extra_in1,
  output logic             gate_out,
  output logic             trig_out,
  output stamp_s           stamp_out,
  output logic             irq
);

  typedef struct packed {
    gate_state_e st;
    logic [31:0] src_mask;
    logic [31:0] gate_mode;
    logic [31:0] stretch;
    logic        stamp_en;
    logic        trig_en;
    logic [1:0]  chan;
    logic [31:0] pre;
    logic [31:0] post;
    logic [31:0] memsize;
    logic [31:0] stamp_cnt;
    logic [31:0] start_stamp;
    logic [31:0] end_stamp;
    logic [31:0] seg_len;
    logic [31:0] stored;
    logic [31:0] tail;
    logic        prev_lvl;
    logic        gate;
    logic        trig;
    stamp_s      stamp;
    logic [2:0]  irq_st;
    logic [2:0]  irq_en;
    logic        irq;
    logic        wr_pend;
    logic        rd_pend;
    logic [29:0] dph_idx;
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
  } gate_state_s;

  gate_state_s s;
  gate_state_s next_s;
  logic [2:0]  synced;
  logic        lvl;
  logic        rise;
  logic        fall;
  logic        open_c;
  logic        close_c;
  logic        two_edge;

  //////////////////////////////////////////////////////////////////////////
  input_sync #(
    .WIDTH  (3),
    .STAGES (2)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .raw     ({extra_in1, extra_in0, ext_trig_in}),
    .synced  (synced)
  );

  // masked inputs are or-ed before edge detection
  assign lvl = (synced[0] & s.src_mask[EXTERNAL_INPUT_ENABLE_BIT])
             | (synced[1] & s.src_mask[EXTRA_INPUT0_ENABLE_BIT])
             | (synced[2] & s.src_mask[EXTRA_INPUT1_ENABLE_BIT]);
  assign rise = lvl & ~s.prev_lvl;
  assign fall = ~lvl & s.prev_lvl;
  assign two_edge = s.gate_mode[TWO_EDGE_FLAG];

  // edge modes look only at transitions; level modes look at the level
  always_comb begin
    open_c  = 1'b0;
    close_c = 1'b0;
    if (s.gate_mode[RISING_POLARITY_CODE]) begin
      open_c  = rise;
      close_c = two_edge ? rise : fall;
    end else if (s.gate_mode[FALLING_POLARITY_CODE]) begin
      open_c  = fall;
      close_c = two_edge ? fall : rise;
    end else if (s.gate_mode[HIGH_LEVEL_CODE]) begin
      open_c  = lvl;
      close_c = ~lvl;
    end else if (s.gate_mode[LOW_LEVEL_CODE]) begin
      open_c  = ~lvl;
      close_c = lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // unmapped indices and the clear register read as zero
  function automatic logic [31:0] read_mux(input gate_state_s r,
                                           input logic [29:0] idx);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (idx)
      IDX_SOURCE_MASK: v = r.src_mask;
      IDX_GATE_MODE:   v = r.gate_mode;
      IDX_OUT_STRETCH: v = r.stretch;
      IDX_CONTROL:     v = {26'h0, r.chan, r.trig_en, r.stamp_en,
                            2'h0};
      IDX_STATUS:      v = {27'h0, r.trig, r.gate, r.st};
      IDX_PRETRIGGER:  v = r.pre;
      IDX_POSTTRIGGER: v = r.post;
      IDX_MEMSIZE:     v = r.memsize;
      IDX_START_STAMP: v = r.start_stamp;
      IDX_END_STAMP:   v = r.end_stamp;
      IDX_SEG_LENGTH:  v = r.seg_len;
      IDX_IRQ_STATUS:  v = {29'h0, r.irq_st};
      IDX_IRQ_ENABLE:  v = {29'h0, r.irq_en};
      default:         v = 32'h00000000;
    endcase
    return v;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [2:0]  ev;
    logic [2:0]  clr;
    logic [31:0] len;
    logic [31:0] pad;
    logic [31:0] mask;
    logic        mem_full;
    logic        seg_end;
    ev       = 3'h0;
    clr      = 3'h0;
    pad      = 32'h00000000;
    len      = s.stamp_cnt - s.start_stamp;
    mask     = ALIGN_MASK_1CH;
    if (s.chan == 2'h1) begin
      mask = ALIGN_MASK_2CH;
    end else if (s.chan == 2'h2) begin
      mask = ALIGN_MASK_4CH;
    end
    pad      = (32'h00000000 - len) & mask;
    // pretrigger counts as stored, so a tiny memsize ends at the first cycle
    mem_full = (s.stored + 32'h00000001) >= s.memsize;
    seg_end  = 1'b0;
    next_s   = s;
    next_s.stamp.valid  = 1'b0;
    next_s.stamp.is_end = 1'b0;
    next_s.prev_lvl     = lvl;
    if (s.st != ST_IDLE && s.st != ST_DONE) begin
      next_s.stamp_cnt = s.stamp_cnt + 32'h00000001;
    end

    unique case (s.st)
      ST_IDLE: begin
        next_s.gate = 1'b0;
      end
      ST_ARMED: begin
        if (open_c) begin
          next_s.st          = ST_OPEN;
          next_s.gate        = 1'b1;
          next_s.start_stamp = s.stamp_cnt;
          // pretrigger samples are already in memory at gate start
          next_s.stored = s.stored + s.pre + 32'h00000001;
          next_s.stamp.valid = s.stamp_en;
          next_s.stamp.value = s.stamp_cnt;
          ev[IRQ_OPENED] = 1'b1;
          if (s.trig_en) begin
            next_s.trig = 1'b1;
          end
        end
      end
      ST_OPEN: begin
        next_s.stored = s.stored + 32'h00000001;
        if (mem_full) begin
          next_s.st           = ST_DONE;
          next_s.gate         = 1'b0;
          next_s.end_stamp    = s.stamp_cnt;
          next_s.seg_len      = len + s.pre + 32'h00000001;
          next_s.stamp.valid  = s.stamp_en;
          next_s.stamp.is_end = 1'b1;
          next_s.stamp.value  = s.stamp_cnt;
          ev[IRQ_DONE] = 1'b1;
        end else if (close_c) begin
          next_s.gate         = 1'b0;
          next_s.end_stamp    = s.stamp_cnt;
          next_s.seg_len      = len + pad + s.pre + s.post;
          next_s.tail         = pad + s.post;
          next_s.stamp.valid  = s.stamp_en;
          next_s.stamp.is_end = 1'b1;
          next_s.stamp.value  = s.stamp_cnt;
          ev[IRQ_CLOSED] = 1'b1;
          if ((pad + s.post) == 32'h00000000) begin
            next_s.st = ST_ARMED;
            seg_end   = 1'b1;
          end else begin
            next_s.st = ST_TAIL;
          end
        end
      end
      ST_TAIL: begin
        // tail holds alignment padding then posttrigger samples
        next_s.stored = s.stored + 32'h00000001;
        next_s.tail   = s.tail - 32'h00000001;
        if (mem_full) begin
          next_s.st    = ST_DONE;
          ev[IRQ_DONE] = 1'b1;
        end else if (s.tail == 32'h00000001) begin
          next_s.st = ST_ARMED;
          seg_end   = 1'b1;
        end
      end
      ST_DONE: begin
        next_s.gate = 1'b0;
        next_s.trig = 1'b0;
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
    // stretched output waits for the end of the whole acquisition
    if (seg_end && !s.stretch[0]) begin
      next_s.trig = 1'b0;
    end
    if (ev[IRQ_DONE]) begin
      next_s.trig = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // reads take one wait state so that read data come from a flop
    next_s.hready = 1'b1;
    next_s.hresp  = 1'b0;
    if (s.rd_pend) begin
      next_s.hrdata  = read_mux(s, s.dph_idx);
      next_s.rd_pend = 1'b0;
    end
    if (s.wr_pend) begin
      next_s.wr_pend = 1'b0;
      unique case (s.dph_idx)
        IDX_SOURCE_MASK: next_s.src_mask  = hwdata;
        IDX_GATE_MODE:   next_s.gate_mode = hwdata;
        IDX_OUT_STRETCH: next_s.stretch   = hwdata;
        IDX_PRETRIGGER:  next_s.pre       = hwdata;
        IDX_POSTTRIGGER: next_s.post      = hwdata;
        IDX_MEMSIZE:     next_s.memsize   = hwdata;
        IDX_IRQ_CLEAR:   clr              = hwdata[2:0];
        IDX_IRQ_ENABLE:  next_s.irq_en    = hwdata[2:0];
        IDX_CONTROL: begin
          next_s.stamp_en = hwdata[CTRL_STAMP_EN];
          next_s.trig_en  = hwdata[CTRL_TRIG_EN];
          next_s.chan     = hwdata[CTRL_CHAN_LO+1:CTRL_CHAN_LO];
          if (hwdata[CTRL_STOP]) begin
            next_s.st   = ST_DONE;
            next_s.gate = 1'b0;
            next_s.trig = 1'b0;
          end else if (hwdata[CTRL_START]) begin
            // arming starts the stamp clock; level seen now is history
            next_s.st        = ST_ARMED;
            next_s.stamp_cnt = 32'h00000000;
            next_s.stored    = 32'h00000000;
            next_s.gate      = 1'b0;
            next_s.trig      = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      next_s.dph_idx = haddr[31:2];
      if (hwrite) begin
        next_s.wr_pend = 1'b1;
      end else begin
        next_s.rd_pend = 1'b1;
        next_s.hready  = 1'b0;
      end
    end

    // a new event beats a clear in the same cycle
    next_s.irq_st = (s.irq_st & ~clr) | ev;
    next_s.irq    = |(next_s.irq_st & next_s.irq_en);
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s           <= '0;
      s.st        <= ST_IDLE;
      s.src_mask  <= RST_SOURCE_MASK;
      s.gate_mode <= RST_GATE_MODE;
      s.stretch   <= RST_OUT_STRETCH;
      s.pre       <= RST_PRETRIGGER;
      s.post      <= RST_POSTTRIGGER;
      s.memsize   <= RST_MEMSIZE;
      s.hready    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign hrdata    = s.hrdata;
  assign hreadyout = s.hready;
  assign hresp     = s.hresp;
  assign gate_out  = s.gate;
  assign trig_out  = s.trig;
  assign stamp_out = s.stamp;
  assign irq       = s.irq;

endmodule

// ===== hdl/gate_trigger_pkg.sv
// package of register indices, field positions, reset values and types
// for the gated sampling trigger block.
// assumes a 32-bit AHB-Lite bus and one sample clock domain.
package gate_trigger_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [29:0] IDX_SOURCE_MASK = 30'h00009dda;
  localparam logic [29:0] IDX_GATE_MODE   = 30'h00009e3e;
  localparam logic [29:0] IDX_OUT_STRETCH = 30'h0003107e;
  localparam logic [29:0] IDX_CONTROL     = 30'h00000100;
  localparam logic [29:0] IDX_STATUS      = 30'h00000101;
  localparam logic [29:0] IDX_PRETRIGGER  = 30'h00000102;
  localparam logic [29:0] IDX_POSTTRIGGER = 30'h00000103;
  localparam logic [29:0] IDX_MEMSIZE     = 30'h00000104;
  localparam logic [29:0] IDX_START_STAMP = 30'h00000105;
  localparam logic [29:0] IDX_END_STAMP   = 30'h00000106;
  localparam logic [29:0] IDX_SEG_LENGTH  = 30'h00000107;
  localparam logic [29:0] IDX_IRQ_STATUS  = 30'h00000108;
  localparam logic [29:0] IDX_IRQ_CLEAR   = 30'h00000109;
  localparam logic [29:0] IDX_IRQ_ENABLE  = 30'h0000010a;

  //////////////////////////////////////////////////////////////////////////
  // source mask bits
  localparam int EXTERNAL_INPUT_ENABLE_BIT = 1;
  localparam int EXTRA_INPUT0_ENABLE_BIT   = 8;
  localparam int EXTRA_INPUT1_ENABLE_BIT   = 9;

  // gate mode bits
  localparam int RISING_POLARITY_CODE  = 0;
  localparam int FALLING_POLARITY_CODE = 1;
  localparam int HIGH_LEVEL_CODE       = 3;
  localparam int LOW_LEVEL_CODE        = 4;
  localparam int TWO_EDGE_FLAG         = 27;

  // control register bits
  localparam int CTRL_START    = 0;
  localparam int CTRL_STOP     = 1;
  localparam int CTRL_STAMP_EN = 2;
  localparam int CTRL_TRIG_EN  = 3;
  localparam int CTRL_CHAN_LO  = 4;

  // interrupt bits
  localparam int IRQ_OPENED = 0;
  localparam int IRQ_CLOSED = 1;
  localparam int IRQ_DONE   = 2;

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [31:0] RST_SOURCE_MASK = 32'h00000000;
  localparam logic [31:0] RST_GATE_MODE   = 32'h00000000;
  localparam logic [31:0] RST_OUT_STRETCH = 32'h00000000;
  localparam logic [31:0] RST_PRETRIGGER  = 32'h00000000;
  localparam logic [31:0] RST_POSTTRIGGER = 32'h00000000;
  localparam logic [31:0] RST_MEMSIZE     = 32'hffffffff;

  // gate alignment masks for 8-bit samples: 1, 2 and 4 active channels
  localparam logic [31:0] ALIGN_MASK_1CH = 32'h00000003;
  localparam logic [31:0] ALIGN_MASK_2CH = 32'h00000001;
  localparam logic [31:0] ALIGN_MASK_4CH = 32'h00000000;

  //////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ARMED = 3'b001,
    ST_OPEN  = 3'b010,
    ST_TAIL  = 3'b011,
    ST_DONE  = 3'b100
  } gate_state_e;

  typedef struct packed {
    logic        valid;
    logic        is_end;
    logic [31:0] value;
  } stamp_s;

endpackage

// ===== hdl/input_sync.sv
// two-flop synchroniser bank for the ttl trigger inputs.
// assumes inputs are asynchronous to hclk; output is the last stage.
`timescale 1ns/1ps
module input_sync
  import gate_trigger_pkg::*;
#(
  parameter int WIDTH  = 3,
  parameter int STAGES = 2
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] synced
);

  if (WIDTH < 1 || STAGES < 2) begin : g_check
    $error("input_sync needs WIDTH >= 1 and STAGES >= 2");
  end

  typedef struct packed {
    logic [STAGES-1:0][WIDTH-1:0] pipe;
  } sync_state_s;

  sync_state_s s;
  sync_state_s next_s;

  // first stage feeds only the second stage
  always_comb begin
    next_s = s;
    next_s.pipe = {s.pipe[STAGES-2:0], raw};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign synced = s.pipe[STAGES-1];

endmodule

// ===== test/gate_trigger_assertions.sv
// timing checks on the gated sampling trigger top-level ports.
// assumes one clock domain, hclk, with active-low reset hresetn.
`timescale 1ns/1ps
module gate_trigger_assertions
  import gate_trigger_pkg::*;
(
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       gate_out,
  input wire logic       trig_out,
  input wire stamp_s     stamp_out,
  input wire logic       irq
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  //////////////////////////////////////////////////////////////////////////
  a_open_stamp_edge: assert property (
    stamp_out.valid && !stamp_out.is_end |-> $rose(gate_out))
    else $error("start stamp without gate opening");
  a_end_stamp_edge: assert property (
    stamp_out.valid && stamp_out.is_end |-> $fell(gate_out))
    else $error("end stamp without gate closing");
  a_trig_with_gate: assert property (
    $rose(trig_out) |-> $rose(gate_out))
    else $error("trigger output rose without a gate");
  a_trig_low_closed: assert property (
    $fell(trig_out) |-> !gate_out)
    else $error("trigger output fell inside a gate");
  a_trig_holds_open: assert property (
    gate_out && $past(gate_out) && $past(trig_out) |-> trig_out)
    else $error("trigger output dropped while gate open");
  // a nonzero tail after a close keeps reopen at least one cycle away; with no padding or post there is none
  a_no_quick_reopen: assert property (
    $fell(gate_out) |=> !gate_out)
    else $error("gate reopened right after closing");
  a_read_one_wait: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  a_resp_okay: assert property (
    hresp == 1'b0)
    else $error("error response seen");
  c_gate_open: cover property ($rose(gate_out));
  c_end_stamp: cover property (stamp_out.valid && stamp_out.is_end);
  c_irq_rise: cover property ($rose(irq));
endmodule
bind gate_trigger gate_trigger_assertions gate_trigger_assertions_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .gate_out(gate_out), .trig_out(trig_out),
  .stamp_out(stamp_out), .irq(irq));

// ===== test/gate_trigger_test.sv
// self-checking bench: register bus tasks, gate scenarios and verdict.
// assumes the ttl source model drives the three trigger pins.
`timescale 1ns/1ps
module gate_trigger_test;
  import gate_trigger_pkg::*;
  logic        hclk, hresetn, hwrite, hreadyout, hresp;
  logic        gate_out, trig_out, irq;
  logic [1:0]  htrans;
  logic [2:0]  want, pins;
  logic [31:0] haddr, hwdata, hrdata, rd, gcnt, scnt;
  stamp_s      stamp_out;
  int          error_cnt, total_checks;
  gate_trigger gate_trigger_i (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ext_trig_in(pins[0]),
    .extra_in0(pins[1]), .extra_in1(pins[2]), .gate_out(gate_out),
    .trig_out(trig_out), .stamp_out(stamp_out), .irq(irq));
  ttl_source_model ttl_source_model_i (.hclk(hclk), .want(want),
    .pins(pins));
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (gate_out === 1'b1) gcnt <= gcnt + 32'h1;
    if (stamp_out.valid === 1'b1) scnt <= scnt + 32'h1;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // entered just after a rising edge; returns just after one
  task automatic bus(input logic [29:0] idx, input logic w,
                     input logic [31:0] wd);
    htrans <= 2'h2;
    haddr <= {idx, 2'h0};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [29:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask
  task automatic rdchk(input logic [29:0] idx, input logic [31:0] e);
    bus(idx, 1'b0, 32'h0);
    chk(rd, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // stop, then mode, mask and start with stamps and trigger output on
  task automatic arm(input logic [31:0] mode, input logic [31:0] mask);
    wr(IDX_CONTROL, 32'h2);
    wr(IDX_GATE_MODE, mode);
    wr(IDX_SOURCE_MASK, mask);
    wr(IDX_CONTROL, 32'hd);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdchk(IDX_SOURCE_MASK, 32'h0);
    rdchk(IDX_GATE_MODE, 32'h0);
    rdchk(IDX_OUT_STRETCH, 32'h0);
    rdchk(IDX_MEMSIZE, 32'hffffffff);
    wr(IDX_SOURCE_MASK, 32'h302);
    rdchk(IDX_SOURCE_MASK, 32'h302);
    rdchk(30'h00000200, 32'h0);
    $display("test t_regs done");
  endtask
  task automatic t_modes;
    logic [31:0] m [6] = '{32'h1, 32'h2, 32'h8, 32'h10, 32'h08000001,
                           32'h08000002};
    logic        a;
    for (int i = 0; i < 6; i++) begin
      a = m[i][0] | m[i][3];
      want <= {3{a}};
      arm(m[i], 32'h2);
      cyc(8);
      if (m[i][3] | m[i][4]) chk(32'(gate_out), 32'h1);
      else chk(32'(gate_out), 32'h0);
      want <= {3{!a}};
      cyc(8);
      chk(32'(gate_out), 32'h0);
      want <= {3{a}};
      cyc(8);
      chk(32'(gate_out), 32'h1);
      want <= {3{!a}};
      cyc(8);
      chk(32'(gate_out), {31'h0, m[i][27]});
      want <= {3{a}};
      cyc(8);
      chk(32'(gate_out), {31'h0, !m[i][27]});
    end
    wr(IDX_CONTROL, 32'h2);
    $display("test t_modes done");
  endtask
  task automatic t_stamps;
    logic [31:0] s;
    want <= 3'h0;
    wr(IDX_PRETRIGGER, 32'h2);
    wr(IDX_POSTTRIGGER, 32'h3);
    wr(IDX_IRQ_ENABLE, 32'h1);
    arm(32'h1, 32'h2);
    gcnt <= 32'h0;
    want <= 3'h7;
    cyc(8);
    chk(32'(trig_out), 32'h1);
    cyc(3);
    want <= 3'h0;
    cyc(12);
    chk(gcnt, 32'd11);
    chk(32'(trig_out), 32'h0);
    bus(IDX_START_STAMP, 1'b0, 32'h0);
    s = rd;
    bus(IDX_END_STAMP, 1'b0, 32'h0);
    chk(rd - s, 32'd11);
    // 11 rounds up to 12, then 2 before and 3 after
    rdchk(IDX_SEG_LENGTH, 32'd17);
    rdchk(IDX_IRQ_STATUS, 32'h3);
    chk(32'(irq), 32'h1);
    wr(IDX_IRQ_CLEAR, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0);
    $display("test t_stamps done");
  endtask
  task automatic t_mask;
    want <= 3'h0;
    arm(32'h8, 32'h100);
    want <= 3'h5;
    cyc(8);
    chk(32'(gate_out), 32'h0);
    want <= 3'h2;
    cyc(8);
    chk(32'(gate_out), 32'h1);
    wr(IDX_SOURCE_MASK, 32'h200);
    cyc(8);
    chk(32'(gate_out), 32'h0);
    $display("test t_mask done");
  endtask
  // a nine-sample gate rounds to ten with two channels, nine with four
  task automatic t_align;
    for (int c = 1; c < 3; c++) begin
      want <= 3'h0;
      arm(32'h1, 32'h2);
      wr(IDX_CONTROL, 32'hd | (32'(c) << 4));
      want <= 3'h7;
      cyc(9);
      want <= 3'h0;
      cyc(12);
      rdchk(IDX_SEG_LENGTH, (c == 1) ? 32'd15 : 32'd14);
      rdchk(IDX_STATUS, 32'h1);
      rdchk(IDX_CONTROL, 32'hc | (32'(c) << 4));
    end
    $display("test t_align done");
  endtask
  task automatic t_stretch;
    logic [31:0] s;
    want <= 3'h0;
    wr(IDX_OUT_STRETCH, 32'h1);
    wr(IDX_MEMSIZE, 32'd40);
    wr(IDX_IRQ_ENABLE, 32'h4);
    arm(32'h1, 32'h2);
    scnt <= 32'h0;
    want <= 3'h7;
    cyc(6);
    want <= 3'h0;
    cyc(12);
    chk(32'(trig_out), 32'h1);
    want <= 3'h7;
    cyc(60);
    chk(32'(gate_out), 32'h0);
    chk(32'(trig_out), 32'h0);
    chk(32'(irq), 32'h1);
    // two start stamps, one end stamp and the extra one at expiry
    chk(scnt, 32'd4);
    bus(IDX_START_STAMP, 1'b0, 32'h0);
    s = rd;
    bus(IDX_END_STAMP, 1'b0, 32'h0);
    s = rd - s;
    // expiry cuts the tail: no padding and no post samples
    rdchk(IDX_SEG_LENGTH, s + 32'd3);
    $display("test t_stretch done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    want = 3'h0;
    gcnt = 32'h0;
    scnt = 32'h0;
    error_cnt = 0;
    total_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs;
    t_modes;
    t_stamps;
    t_mask;
    t_align;
    t_stretch;
    end_of_test;
  end
  // tests need about 600 cycles; 10000 marks a hang
  initial begin
    #100000;
    error_cnt++;
    end_of_test;
  end
endmodule

// ===== test/ttl_source_model.sv
// ttl trigger source model for the gated sampling trigger bench.
// assumes the bench requests pin levels just after a rising hclk edge.
`timescale 1ns/1ps
module ttl_source_model #(
  parameter int SKEW = 3
) (
  input  wire logic       hclk,
  input  wire logic [2:0] want,
  output logic      [2:0] pins
);
  initial pins = 3'h0;
  // skewed off the edge: the source is unrelated to the sample clock
  // ttl lines are always driven, so no released level is modelled
  always @(posedge hclk) begin
    pins <= #(SKEW) want;
  end
endmodule
